// ==== rtl/trg_pkg.sv ====
`default_nettype none
package trg_pkg;
    // Parameter register offsets
    localparam logic [15:0] TRG_CMD_ADDR = 16'h0000;
    localparam logic [15:0] TRG_SEL_ADDR = 16'h9c40;
    localparam logic [15:0] TRG_DIR_ADDR = 16'h9ca4;
    localparam logic [15:0] TRG_TERM_ADDR = 16'h9cae;
    localparam logic [15:0] TRG_WIDTH_ADDR = 16'habe0;
    // Command and mode codes
    localparam logic [31:0] FORCE_EVENT_CMD = 32'h0000_0010;
    localparam logic [31:0] FREE_RUN_CODE = 32'h0000_0000;
    localparam logic [31:0] RISING_EDGE_CODE = 32'h0000_4e20;
    localparam logic [31:0] FALLING_EDGE_CODE = 32'h0000_4e2a;
    localparam logic [31:0] ANY_EDGE_CODE = 32'h0000_4e3e;
    localparam logic [31:0] LONG_HIGH_CODE = 32'h0000_4e21;
    localparam logic [31:0] SHORT_HIGH_CODE = 32'h0000_4e22;
    localparam logic [31:0] LONG_LOW_CODE = 32'h0000_4e2b;
    localparam logic [31:0] SHORT_LOW_CODE = 32'h0000_4e2c;
    localparam logic [31:0] PIN_OUT_CODE = 32'h0000_0001;
    localparam logic [31:0] TERM_50_CODE = 32'h0000_0001;
    // Reset values
    localparam logic [31:0] TRG_SEL_RST = 32'h0000_0000;
    localparam logic TRG_DIR_RST = 1'b0;
    localparam logic TRG_TERM_RST = 1'b0;
    // Pulse width limits and run counter
    localparam logic [7:0] WIDTH_MIN = 8'h02;
    localparam logic [7:0] WIDTH_MAX = 8'hff;
    localparam logic [7:0] WIDTH_RST = 8'h02;
    localparam int RUN_W = 9;
    localparam logic [RUN_W-1:0] RUN_ONE = 9'h001;
    localparam logic [RUN_W-1:0] RUN_MAX = 9'h100;
    typedef enum logic [1:0] {
        TRG_IDLE = 2'b00,
        TRG_ARMED = 2'b01,
        TRG_REC = 2'b10
    } trg_state_t;
endpackage
`default_nettype wire

// ==== rtl/trg_ext_det.sv ====
`default_nettype none
module trg_ext_det
    import trg_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic pin_i,
    input wire logic [7:0] width,
    output logic rise,
    output logic fall,
    output logic long_high,
    output logic short_high,
    output logic long_low,
    output logic short_low
);
    logic sync1_q;
    logic sync2_q;
    logic prev_q;
    logic [RUN_W-1:0] run_q;
    logic [RUN_W-1:0] width_ext;
    logic chg;

    assign width_ext = {1'b0, width};
    assign chg = sync2_q != prev_q;

    // Two-stage synchroniser, then one stage for history
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            prev_q <= 1'b0;
        end
        else
        begin
            sync1_q <= pin_i;
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end

    // Length of the current level run, saturating
    always_ff @(posedge clock)
    begin
        if (rst)
            run_q <= RUN_ONE;
        else if (chg)
            run_q <= RUN_ONE;
        else if (run_q != RUN_MAX)
            run_q <= run_q + RUN_ONE;
    end

    // Registered event pulses
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            rise <= 1'b0;
            fall <= 1'b0;
            long_high <= 1'b0;
            short_high <= 1'b0;
            long_low <= 1'b0;
            short_low <= 1'b0;
        end
        else
        begin
            rise <= chg && sync2_q;
            fall <= chg && !sync2_q;
            // Fires once the run outlasts the width, never at its end
            long_high <= !chg && prev_q && run_q == width_ext;
            short_high <= chg && prev_q && run_q < width_ext;
            long_low <= !chg && !prev_q && run_q == width_ext;
            short_low <= chg && !prev_q && run_q < width_ext;
        end
    end

    a_sync_two: assert property (@(posedge clock) disable iff (rst)
        $rose(sync2_q) |=> rise)
        else $error("rising edge not reported one cycle after sync");
    a_long_span: assert property (@(posedge clock) disable iff (rst)
        long_high |-> $past(prev_q) && $past(run_q) == $past(width_ext))
        else $error("long high pulse reported at wrong run length");
endmodule
`default_nettype wire

// ==== rtl/trg_mode_ctrl.sv ====
`default_nettype none
module trg_mode_ctrl
    import trg_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic param_wr,
    input wire logic param_rd,
    input wire logic [15:0] param_addr,
    input wire logic [31:0] param_wdata,
    output logic [31:0] param_rdata,
    input wire logic acq_start,
    input wire logic rec_done,
    input wire logic trig_pin_i,
    output logic trig_pin_o,
    output logic trig_pin_oe,
    output logic term_50_en,
    output logic ext_in_en,
    output logic trig_armed,
    output logic trig_event
);
    logic [31:0] cmd_q;
    logic [31:0] sel_q;
    logic dir_q;
    logic term_q;
    logic [7:0] width_q;
    trg_state_t state_q;
    trg_state_t state_d;
    logic trig_q;
    logic ext_mode;
    logic sw_mode;
    logic ext_hit;
    logic force_wr;
    logic fire;
    logic wr_width_ok;
    logic ev_rise;
    logic ev_fall;
    logic ev_lhi;
    logic ev_shi;
    logic ev_llo;
    logic ev_slo;

    trg_ext_det u_det (
        .clock(clock),
        .rst(rst),
        .pin_i(trig_pin_i),
        .width(width_q),
        .rise(ev_rise),
        .fall(ev_fall),
        .long_high(ev_lhi),
        .short_high(ev_shi),
        .long_low(ev_llo),
        .short_low(ev_slo)
    );

    // Mode decode and event selection
    always_comb
    begin
        ext_mode = 1'b1;
        ext_hit = 1'b0;
        case (sel_q)
            RISING_EDGE_CODE: ext_hit = ev_rise;
            FALLING_EDGE_CODE: ext_hit = ev_fall;
            ANY_EDGE_CODE: ext_hit = ev_rise || ev_fall;
            LONG_HIGH_CODE: ext_hit = ev_lhi;
            SHORT_HIGH_CODE: ext_hit = ev_shi;
            LONG_LOW_CODE: ext_hit = ev_llo;
            SHORT_LOW_CODE: ext_hit = ev_slo;
            default: ext_mode = 1'b0;
        endcase
    end

    assign sw_mode = sel_q == FREE_RUN_CODE;
    assign force_wr = param_wr && param_addr == TRG_CMD_ADDR
        && param_wdata == FORCE_EVENT_CMD;
    assign wr_width_ok = param_wdata >= {24'h0, WIDTH_MIN}
        && param_wdata <= {24'h0, WIDTH_MAX};
    // Trigger only from the armed state
    assign fire = state_q == TRG_ARMED
        && (sw_mode || ext_hit || force_wr);

    // Parameter register writes
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            cmd_q <= FREE_RUN_CODE;
            sel_q <= TRG_SEL_RST;
            dir_q <= TRG_DIR_RST;
            term_q <= TRG_TERM_RST;
            width_q <= WIDTH_RST;
        end
        else if (param_wr)
        begin
            case (param_addr)
                TRG_CMD_ADDR: cmd_q <= param_wdata;
                TRG_SEL_ADDR: sel_q <= param_wdata;
                TRG_DIR_ADDR: dir_q <= param_wdata == PIN_OUT_CODE;
                TRG_TERM_ADDR: term_q <= param_wdata == TERM_50_CODE;
                TRG_WIDTH_ADDR:
                begin
                    if (wr_width_ok)
                        width_q <= param_wdata[7:0];
                end
                default: ;
            endcase
        end
    end

    // Registered read data, zero for unmapped offsets
    always_ff @(posedge clock)
    begin
        if (rst)
            param_rdata <= 32'h0000_0000;
        else if (param_rd)
        begin
            case (param_addr)
                TRG_CMD_ADDR: param_rdata <= cmd_q;
                TRG_SEL_ADDR: param_rdata <= sel_q;
                TRG_DIR_ADDR: param_rdata <= {31'h0, dir_q};
                TRG_TERM_ADDR: param_rdata <= {31'h0, term_q};
                TRG_WIDTH_ADDR: param_rdata <= {24'h0, width_q};
                default: param_rdata <= 32'h0000_0000;
            endcase
        end
    end

    // Acquisition sequencing
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            TRG_IDLE:
            begin
                if (acq_start)
                    state_d = TRG_ARMED;
            end
            TRG_ARMED:
            begin
                if (fire)
                    state_d = TRG_REC;
            end
            TRG_REC:
            begin
                if (rec_done)
                    state_d = TRG_ARMED;
            end
            default: state_d = TRG_IDLE;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            state_q <= TRG_IDLE;
        else
            state_q <= state_d;
    end

    // One-cycle trigger pulse, registered from fire in the armed state
    always_ff @(posedge clock)
    begin
        if (rst)
            trig_q <= 1'b0;
        else
            trig_q <= fire;
    end

    // Connector direction, termination and status
    assign trig_pin_oe = dir_q && !ext_mode;
    assign trig_pin_o = trig_pin_oe && trig_q;
    assign term_50_en = ext_mode && term_q;
    assign ext_in_en = ext_mode;
    assign trig_armed = state_q == TRG_ARMED;
    assign trig_event = trig_q;

    a_sw_start: assert property (@(posedge clock) disable iff (rst)
        state_q == TRG_IDLE && acq_start && sw_mode && !param_wr
        |=> ##1 trig_q)
        else $error("free-run mode did not trigger after start");
    a_force_armed: assert property (@(posedge clock) disable iff (rst)
        force_wr |=> trig_q == ($past(state_q) == TRG_ARMED))
        else $error("force command misbehaved");
    a_pin_off: assert property (@(posedge clock) disable iff (rst)
        !dir_q |-> !trig_pin_oe && !trig_pin_o)
        else $error("driver enabled with direction zero");
    a_pin_drive: assert property (@(posedge clock) disable iff (rst)
        dir_q && !ext_mode && trig_q |-> trig_pin_oe && trig_pin_o)
        else $error("internal trigger not driven out");
    a_ext_input: assert property (@(posedge clock) disable iff (rst)
        ext_in_en |-> !trig_pin_oe)
        else $error("connector driven in external mode");
    a_term_sel: assert property (@(posedge clock) disable iff (rst)
        term_50_en == (ext_in_en && term_q))
        else $error("termination select wrong");
    a_one_shot: assert property (@(posedge clock) disable iff (rst)
        trig_q |-> !trig_q [*1] ##0 1 or state_q == TRG_REC ##1 1)
        else $error("trigger pulse longer than one cycle");
    a_rearm_wait: assert property (@(posedge clock) disable iff (rst)
        state_q == TRG_REC && !rec_done |=> !trig_q)
        else $error("trigger while recording");
    a_width_range: assert property (@(posedge clock) disable iff (rst)
        width_q >= WIDTH_MIN)
        else $error("pulse width below minimum");
    a_rise_hit: assert property (@(posedge clock) disable iff (rst)
        state_q == TRG_ARMED && sel_q == RISING_EDGE_CODE && ev_rise
        |=> trig_q)
        else $error("rising edge mode missed an edge");
endmodule
`default_nettype wire

// ==== dv/trg_src.sv ====
`default_nettype none
module trg_src (
    input wire logic clock,
    input wire logic idle_lvl,
    output logic pin
);
    timeunit 1ns;
    timeprecision 100ps;
    logic busy = 1'b0;
    // One source per board; the line rests at its idle level between pulses
    assign pin = busy ? ~idle_lvl : idle_lvl;
    // Pulse length counted in whole sample clock periods
    task automatic pulse(input int len);
        @(negedge clock);
        busy = 1'b1;
        repeat (len) @(negedge clock);
        busy = 1'b0;
    endtask
endmodule
`default_nettype wire

// ==== dv/trigger_mode_control_tb.sv ====
`default_nettype none
module trigger_mode_control_tb
    import trg_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct {
        logic [31:0] mode;
        logic idle;
        int len;
        logic ext;
        logic fire;
    } trg_row_t;
    trg_row_t rows [12];
    logic clock = 1'b0, rst = 1'b1, param_wr = 1'b0, param_rd = 1'b0;
    logic acq_start = 1'b0, rec_done = 1'b0, idle_lvl = 1'b0;
    logic [15:0] param_addr = 16'h0000;
    logic [31:0] param_wdata = 32'h0000_0000;
    logic [31:0] param_rdata;
    logic trig_pin_i, trig_pin_o, trig_pin_oe, term_50_en;
    logic ext_in_en, trig_armed, trig_event;
    int fail_count = 0, cmp_count = 0, cyc = 0, ev_cnt = 0, pin_hits = 0;
    int e0, p0;

    trg_mode_ctrl dut_u (.clock(clock), .rst(rst), .param_wr(param_wr),
        .param_rd(param_rd), .param_addr(param_addr),
        .param_wdata(param_wdata), .param_rdata(param_rdata),
        .acq_start(acq_start), .rec_done(rec_done),
        .trig_pin_i(trig_pin_i), .trig_pin_o(trig_pin_o),
        .trig_pin_oe(trig_pin_oe), .term_50_en(term_50_en),
        .ext_in_en(ext_in_en), .trig_armed(trig_armed),
        .trig_event(trig_event));
    trg_src src_u (.clock(clock), .idle_lvl(idle_lvl), .pin(trig_pin_i));

    // Sample clock
    initial forever #2.5 clock = ~clock;

    // Event counters and hang guard
    always @(posedge clock)
    begin
        cyc++;
        if (trig_event === 1'b1)
            ev_cnt++;
        if (trig_event === 1'b1 && trig_pin_o === 1'b1 && trig_pin_oe === 1'b1)
            pin_hits++;
        if (cyc >= 5000)
        begin
            fail_count++;
            end_of_test;
        end
    end

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        chk32({31'h0, got}, {31'h0, exp});
    endtask
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(negedge clock);
        param_wr = 1'b1;
        param_addr = a;
        param_wdata = d;
        @(negedge clock);
        param_wr = 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [31:0] exp);
        @(negedge clock);
        param_rd = 1'b1;
        param_addr = a;
        @(negedge clock);
        param_rd = 1'b0;
        @(negedge clock);
        chk32(param_rdata, exp);
    endtask
    task automatic do_reset;
        @(negedge clock);
        rst = 1'b1;
        repeat (6) @(negedge clock);
        rst = 1'b0;
    endtask
    task automatic start_acq;
        @(negedge clock);
        acq_start = 1'b1;
        @(negedge clock);
        acq_start = 1'b0;
    endtask
    task automatic end_of_test;
        $display("counts: compares=%0d mismatches=%0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Mode table with idle level, length, input enable and expected fire
    initial
    begin
        rows = '{'{FREE_RUN_CODE, 1'b0, 3, 1'b0, 1'b1},
            '{RISING_EDGE_CODE, 1'b0, 3, 1'b1, 1'b1},
            '{FALLING_EDGE_CODE, 1'b0, 3, 1'b1, 1'b1},
            '{ANY_EDGE_CODE, 1'b1, 3, 1'b1, 1'b1},
            '{LONG_HIGH_CODE, 1'b0, 5, 1'b1, 1'b1},
            '{LONG_HIGH_CODE, 1'b0, 4, 1'b1, 1'b0},
            '{SHORT_HIGH_CODE, 1'b0, 3, 1'b1, 1'b1},
            '{SHORT_HIGH_CODE, 1'b0, 4, 1'b1, 1'b0},
            '{LONG_LOW_CODE, 1'b1, 5, 1'b1, 1'b1},
            '{LONG_LOW_CODE, 1'b1, 4, 1'b1, 1'b0},
            '{SHORT_LOW_CODE, 1'b1, 3, 1'b1, 1'b1},
            '{SHORT_LOW_CODE, 1'b1, 4, 1'b1, 1'b0}};
        foreach (rows[i])
        begin
            do_reset;
            idle_lvl = rows[i].idle;
            wr(TRG_WIDTH_ADDR, 32'h0000_0004);
            wr(TRG_SEL_ADDR, rows[i].mode);
            repeat (8) @(negedge clock);
            chk1(ext_in_en, rows[i].ext);
            chk1(trig_pin_oe, 1'b0);
            e0 = ev_cnt;
            start_acq;
            repeat (4) @(negedge clock);
            src_u.pulse(rows[i].len);
            repeat (30) @(negedge clock);
            chk32(32'(ev_cnt - e0), {31'h0, rows[i].fire});
            $display("row %0d done", i);
        end
        // Reset values, width limits, unmapped read, termination
        do_reset;
        rd(TRG_SEL_ADDR, FREE_RUN_CODE);
        rd(TRG_WIDTH_ADDR, 32'h0000_0002);
        rd(16'h1234, 32'h0000_0000);
        wr(TRG_WIDTH_ADDR, 32'h0000_0001);
        rd(TRG_WIDTH_ADDR, 32'h0000_0002);
        wr(TRG_WIDTH_ADDR, 32'h0000_0100);
        rd(TRG_WIDTH_ADDR, 32'h0000_0002);
        wr(TRG_WIDTH_ADDR, 32'h0000_00ff);
        rd(TRG_WIDTH_ADDR, 32'h0000_00ff);
        wr(TRG_SEL_ADDR, RISING_EDGE_CODE);
        chk1(term_50_en, 1'b0);
        wr(TRG_TERM_ADDR, TERM_50_CODE);
        @(negedge clock);
        chk1(term_50_en, 1'b1);
        rd(TRG_TERM_ADDR, 32'h0000_0001);
        $display("registers done");
        // Force command ignored while idle, taken once while armed
        wr(TRG_DIR_ADDR, PIN_OUT_CODE);
        @(negedge clock);
        chk1(trig_pin_oe, 1'b0);
        e0 = ev_cnt;
        p0 = pin_hits;
        wr(TRG_CMD_ADDR, FORCE_EVENT_CMD);
        repeat (3) @(negedge clock);
        chk32(32'(ev_cnt - e0), 32'h0000_0000);
        start_acq;
        repeat (2) @(negedge clock);
        chk1(trig_armed, 1'b1);
        wr(TRG_CMD_ADDR, FORCE_EVENT_CMD);
        repeat (2) @(negedge clock);
        chk32(32'(ev_cnt - e0), 32'h0000_0001);
        chk1(trig_armed, 1'b0);
        chk32(32'(pin_hits - p0), 32'h0000_0000);
        $display("force done");
        // Free run with the connector as a trigger output
        do_reset;
        wr(TRG_DIR_ADDR, PIN_OUT_CODE);
        @(negedge clock);
        chk1(trig_pin_oe, 1'b1);
        chk1(trig_pin_o, 1'b0);
        e0 = ev_cnt;
        p0 = pin_hits;
        start_acq;
        repeat (4) @(negedge clock);
        chk32(32'(ev_cnt - e0), 32'h0000_0001);
        chk32(32'(pin_hits - p0), 32'h0000_0001);
        @(negedge clock);
        rec_done = 1'b1;
        @(negedge clock);
        rec_done = 1'b0;
        repeat (4) @(negedge clock);
        chk32(32'(ev_cnt - e0), 32'h0000_0002);
        $display("free run done");
        end_of_test;
    end
endmodule
`default_nettype wire
